// ---- hw/pin_sync_edge.v ----
// Two-flop pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sync_edge (
    input  wire clk_in,
    input  wire rst_n_in,
    input  wire pin_in,
    output wire level_out,
    output wire rise_out,
    output wire fall_out
);

    reg meta_r;
    reg sync_r;
    reg last_r;

    // Only sync_r reads meta_r; edges come from the settled pair
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level_out = sync_r;
    assign rise_out  = sync_r & ~last_r;
    assign fall_out  = ~sync_r & last_r;

endmodule // pin_sync_edge

`default_nettype wire

// ---- hw/updown_capture_compare_pwm_timer.v ----
// Two-channel 16-bit capture/compare up-counter with fast PWM
// How it works
// - Prescaler ticks only while its enable is set
// - Load enable clears counter; software then releases
// - Count enable makes counter count source ticks
// - Trigger enable starts counting on trigger edge
// - Channel A match or capture clears counter
// - One-shot: channel A match clears count enable
// - Each new trigger restarts a stopped one-shot
// - Mode field picks single/double compare or capture
// - Single writes act now; double waits update
// - Buffer moves on load, on A match if it clears, else on overflow
// - Channel B also updates on channel A capture
// - Pin A polarity flips capture, trigger, output
// - Pin B polarity flips capture, source, output
// - Capture enable gates channel A capture
// - Output code 001: set on match, reset overflow
// - Basic PWM is 8-bit, duty upper bits
// - Full PWM period is resolution-wide counter
// - Pins are sampled; pulses must be long enough
`timescale 1ns/1ps
`default_nettype none
`include "updown_timer_defines.vh"

module updown_capture_compare_pwm_timer (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire [2:0]  count_source_select_in,
    input  wire        prescaler_enable_in,
    input  wire        load_enable_in,
    input  wire        count_enable_wr_in,
    input  wire        count_enable_wdata_in,
    input  wire        trigger_enable_in,
    input  wire        clear_by_chan_a_enable_in,
    input  wire        one_shot_enable_in,
    input  wire [1:0]  chan_a_mode_field_in,
    input  wire [1:0]  chan_b_mode_field_in,
    input  wire        chan_a_polarity_in,
    input  wire        chan_b_polarity_in,
    input  wire        chan_a_capture_enable_in,
    input  wire [2:0]  chan_a_output_mode_in,
    input  wire [2:0]  chan_b_output_mode_in,
    input  wire        fast_pwm_enable_in,
    input  wire [1:0]  pwm_resolution_in,
    input  wire        chan_a_write_in,
    input  wire        chan_b_write_in,
    input  wire [15:0] write_data_in,
    input  wire        trigger_pin_in,
    input  wire        chan_a_pin_in,
    input  wire        chan_b_pin_in,
    output wire        chan_a_pin_out,
    output wire        chan_a_pin_oe_n_out,
    output wire        chan_b_pin_out,
    output wire        chan_b_pin_oe_n_out,
    output wire [15:0] binary_up_counter_out,
    output wire [15:0] chan_a_compare_capture_out,
    output wire [15:0] chan_b_compare_capture_out,
    output wire        count_enable_flag_out
);

    wire        trig_rise;
    wire        trig_fall;
    wire        a_rise;
    wire        a_fall;
    wire        b_rise;
    wire        b_fall;
    reg  [4:0]  presc_r;
    reg         tick;
    reg  [15:0] top_mask;
    reg  [2:0]  extra_shift;
    reg  [15:0] binary_up_counter_r;
    reg  [15:0] binary_up_counter_nxt;
    reg         count_enable_flag_r;
    reg         count_enable_flag_nxt;
    wire        advance;
    wire        overflow;
    wire [31:0] active_w;
    wire [1:0]  match_w;
    wire [1:0]  capture_w;
    wire        a_is_compare;
    wire        a_is_capture;
    wire        a_compare_hit;
    wire        clear_hit;
    wire        update_common;
    wire [1:0]  update_w;
    wire        start_ev;
    wire        stop_ev;
    wire [3:0]  mode_w;
    wire [1:0]  pol_w;
    wire [5:0]  out_mode_w;
    wire [1:0]  write_w;
    wire [1:0]  pin_rise_w;
    wire [1:0]  pin_fall_w;
    wire [1:0]  cap_gate_w;
    wire [1:0]  pin_level_w;
    wire [1:0]  pin_oe_n_w;

    pin_sync_edge u_trig_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (trigger_pin_in),
        .level_out (),
        .rise_out  (trig_rise),
        .fall_out  (trig_fall)
    );

    pin_sync_edge u_a_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (chan_a_pin_in),
        .level_out (),
        .rise_out  (a_rise),
        .fall_out  (a_fall)
    );

    pin_sync_edge u_b_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (chan_b_pin_in),
        .level_out (),
        .rise_out  (b_rise),
        .fall_out  (b_fall)
    );

    // Free-running divider, held at zero while disabled
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_r <= `PRESC_RESET;
        end else if (prescaler_enable_in) begin
            presc_r <= presc_r + 5'h01;
        end else begin
            presc_r <= `PRESC_RESET;
        end
    end

    // Count source tick
    always @* begin
        tick = 1'b0;
        case (count_source_select_in)
            `SRC_IO_CLOCK:   tick = 1'b1;
            `SRC_IO_DIV8:    tick = prescaler_enable_in
                                    & ((presc_r & `PRESC_DIV8_LAST) == `PRESC_DIV8_LAST);
            `SRC_IO_DIV32:   tick = prescaler_enable_in
                                    & (presc_r == `PRESC_DIV32_LAST);
            `SRC_CHAN_B_PIN: tick = chan_b_polarity_in ? b_fall : b_rise;
            default:         tick = 1'b0;
        endcase
    end

    // Wrap point: full 16 bits, or the PWM resolution
    always @* begin
        top_mask    = `COUNTER_ALL_ONES;
        extra_shift = `EXTRA_SHIFT_14;
        if (fast_pwm_enable_in) begin
            case (pwm_resolution_in)
                `RES_10_BITS: begin
                    top_mask    = `MASK_10_BITS;
                    extra_shift = `EXTRA_SHIFT_10;
                end
                `RES_11_BITS: begin
                    top_mask    = `MASK_11_BITS;
                    extra_shift = `EXTRA_SHIFT_11;
                end
                `RES_12_BITS: begin
                    top_mask    = `MASK_12_BITS;
                    extra_shift = `EXTRA_SHIFT_12;
                end
                default: begin
                    top_mask    = `MASK_14_BITS;
                    extra_shift = `EXTRA_SHIFT_14;
                end
            endcase
        end
    end

    assign advance  = count_enable_flag_r & tick;
    assign overflow = advance
                      & ((binary_up_counter_r & top_mask) == top_mask);

    assign a_is_compare  = ~chan_a_mode_field_in[1];
    assign a_is_capture  = chan_a_mode_field_in[1];
    assign a_compare_hit = a_is_compare & advance & match_w[0];
    assign clear_hit     = clear_by_chan_a_enable_in
                           & (a_compare_hit | capture_w[0]);

    assign update_common = load_enable_in
                           | (~clear_by_chan_a_enable_in & overflow)
                           | (clear_by_chan_a_enable_in & a_compare_hit);
    assign update_w[0]   = update_common;
    assign update_w[1]   = update_common
                           | (clear_by_chan_a_enable_in & a_is_capture
                              & capture_w[0]);

    // Counter
    always @* begin
        binary_up_counter_nxt = binary_up_counter_r;
        if (load_enable_in) begin
            binary_up_counter_nxt = `COUNTER_RESET;
        end else if (clear_hit) begin
            binary_up_counter_nxt = `COUNTER_RESET;
        end else if (overflow) begin
            binary_up_counter_nxt = `COUNTER_RESET;
        end else if (advance) begin
            binary_up_counter_nxt = binary_up_counter_r + 16'h0001;
        end
    end

    // Trigger edge follows pin A polarity, opposite to capture
    assign start_ev = trigger_enable_in
                      & (chan_a_polarity_in ? trig_rise : trig_fall);
    assign stop_ev  = one_shot_enable_in & a_compare_hit;

    // Software write first; a restart beats a one-shot stop
    always @* begin
        count_enable_flag_nxt = count_enable_flag_r;
        if (count_enable_wr_in) begin
            count_enable_flag_nxt = count_enable_wdata_in;
        end else if (start_ev) begin
            count_enable_flag_nxt = 1'b1;
        end else if (stop_ev) begin
            count_enable_flag_nxt = 1'b0;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            binary_up_counter_r <= `COUNTER_RESET;
            count_enable_flag_r <= 1'b0;
        end else begin
            binary_up_counter_r <= binary_up_counter_nxt;
            count_enable_flag_r <= count_enable_flag_nxt;
        end
    end

    assign mode_w      = {chan_b_mode_field_in, chan_a_mode_field_in};
    assign pol_w       = {chan_b_polarity_in, chan_a_polarity_in};
    assign out_mode_w  = {chan_b_output_mode_in, chan_a_output_mode_in};
    assign write_w     = {chan_b_write_in, chan_a_write_in};
    assign pin_rise_w  = {b_rise, a_rise};
    assign pin_fall_w  = {b_fall, a_fall};
    assign cap_gate_w  = {1'b1, chan_a_capture_enable_in};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            wire [1:0]  mode     = mode_w[ch*2 +: 2];
            wire [2:0]  out_mode = out_mode_w[ch*3 +: 3];
            reg  [15:0] active_r;
            reg  [15:0] buffer_r;
            reg         out_r;
            reg         pin_level_r;
            reg         pin_oe_n_r;
            wire        edge_hit;
            wire        set_ev;
            wire        reset_ev;
            wire [5:0]  extra;
            wire [5:0]  sub_idx;
            wire [7:0]  thresh;

            // Both-edge mode ignores polarity
            assign edge_hit = mode[0] ? (pin_rise_w[ch] | pin_fall_w[ch])
                              : (pol_w[ch] ? pin_fall_w[ch] : pin_rise_w[ch]);
            assign capture_w[ch] = mode[1] & edge_hit & cap_gate_w[ch];
            assign match_w[ch]   = binary_up_counter_r == active_r;

            // Extra low bits stretch the step by one in early sub-periods
            assign extra   = active_r[7:2] >> extra_shift;
            assign sub_idx = binary_up_counter_r[13:8] & (6'h3f >> extra_shift);
            assign thresh  = ((sub_idx < extra) && (active_r[15:8] != 8'h00))
                             ? active_r[15:8] - 8'h01 : active_r[15:8];

            assign set_ev   = fast_pwm_enable_in
                              ? (advance & (binary_up_counter_r[7:0] == thresh))
                              : (~mode[1] & advance & match_w[ch]);
            assign reset_ev = fast_pwm_enable_in
                              ? (advance & (binary_up_counter_r[7:0] == `BASIC_LAST))
                              : overflow;

            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    active_r <= `COMPARE_RESET;
                    buffer_r <= `COMPARE_RESET;
                end else begin
                    if (write_w[ch]) begin
                        buffer_r <= write_data_in;
                    end
                    if (capture_w[ch]) begin
                        active_r <= binary_up_counter_r;
                    end else if (write_w[ch] && (mode == `MODE_CMP_SINGLE)) begin
                        active_r <= write_data_in;
                    end else if ((mode == `MODE_CMP_DOUBLE) && update_w[ch]) begin
                        active_r <= buffer_r;
                    end
                end
            end

            // Set wins when match and overflow coincide
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    out_r <= 1'b0;
                end else if (load_enable_in) begin
                    out_r <= 1'b0;
                end else if (out_mode == `OUT_SET_MATCH_RESET_OVF) begin
                    if (set_ev) begin
                        out_r <= 1'b1;
                    end else if (reset_ev) begin
                        out_r <= 1'b0;
                    end
                end
            end

            // Registered pin; drives only in compare mode with an output code
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pin_level_r <= 1'b0;
                    pin_oe_n_r  <= 1'b1;
                end else begin
                    pin_level_r <= out_r ^ pol_w[ch];
                    pin_oe_n_r  <= mode[1] | (out_mode == `OUT_HOLD);
                end
            end

            assign active_w[ch*16 +: 16] = active_r;
            assign pin_level_w[ch]       = pin_level_r;
            assign pin_oe_n_w[ch]        = pin_oe_n_r;
        end
    endgenerate

    assign chan_a_pin_out             = pin_level_w[0];
    assign chan_a_pin_oe_n_out        = pin_oe_n_w[0];
    assign chan_b_pin_out             = pin_level_w[1];
    assign chan_b_pin_oe_n_out        = pin_oe_n_w[1];
    assign binary_up_counter_out      = binary_up_counter_r;
    assign chan_a_compare_capture_out = active_w[15:0];
    assign chan_b_compare_capture_out = active_w[31:16];
    assign count_enable_flag_out      = count_enable_flag_r;

endmodule // updown_capture_compare_pwm_timer

`default_nettype wire

// ---- hw/updown_timer_defines.vh ----
// Constants used by the capture/compare timer; its pin sampler uses none
`ifndef UPDOWN_TIMER_DEFINES_VH
`define UPDOWN_TIMER_DEFINES_VH

// Count source select codes
`define SRC_IO_CLOCK        3'h0
`define SRC_IO_DIV8         3'h1
`define SRC_IO_DIV32        3'h2
`define SRC_CHAN_B_PIN      3'h3

// Prescaler taps, counted in I/O clock cycles
`define PRESC_WIDTH         5
`define PRESC_DIV8_LAST     5'h07
`define PRESC_DIV32_LAST    5'h1f
`define PRESC_RESET         5'h00

// Channel mode field codes
`define MODE_CMP_SINGLE     2'h0
`define MODE_CMP_DOUBLE     2'h1
`define MODE_CAP_ONE_EDGE   2'h2
`define MODE_CAP_BOTH_EDGES 2'h3

// Output mode codes
`define OUT_HOLD            3'h0
`define OUT_SET_MATCH_RESET_OVF 3'h1

// Resolution field codes and their full-period masks
`define RES_10_BITS         2'h0
`define RES_11_BITS         2'h1
`define RES_12_BITS         2'h2
`define RES_14_BITS         2'h3
`define MASK_10_BITS        16'h03ff
`define MASK_11_BITS        16'h07ff
`define MASK_12_BITS        16'h0fff
`define MASK_14_BITS        16'h3fff
`define EXTRA_SHIFT_10      3'h4
`define EXTRA_SHIFT_11      3'h3
`define EXTRA_SHIFT_12      3'h2
`define EXTRA_SHIFT_14      3'h0

// Basic PWM step: an 8-bit sub-period
`define BASIC_LAST          8'hff

// Reset values and the full 16-bit wrap mask
`define COUNTER_RESET       16'h0000
`define COMPARE_RESET       16'h0000
`define COUNTER_ALL_ONES    16'hffff

// Least input pulse, in tenths of an I/O clock period
`define PIN_PULSE_MIN_TENTHS 15

`endif

// ---- testbench/timer_checker.sv ----
// Port assertions for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module timer_checker (
    input wire        clk_in,
    input wire        rst_n_in,
    input wire [2:0]  count_source_select_in,
    input wire        prescaler_enable_in,
    input wire        load_enable_in,
    input wire        count_enable_wr_in,
    input wire        count_enable_wdata_in,
    input wire        trigger_enable_in,
    input wire        clear_by_chan_a_enable_in,
    input wire        one_shot_enable_in,
    input wire [1:0]  chan_a_mode_field_in,
    input wire [1:0]  chan_b_mode_field_in,
    input wire        chan_a_polarity_in,
    input wire [2:0]  chan_a_output_mode_in,
    input wire        fast_pwm_enable_in,
    input wire        chan_a_write_in,
    input wire        chan_b_write_in,
    input wire [15:0] write_data_in,
    input wire        chan_a_pin_out,
    input wire [15:0] binary_up_counter_out,
    input wire [15:0] chan_a_compare_capture_out,
    input wire [15:0] chan_b_compare_capture_out,
    input wire        count_enable_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire [15:0] cnt   = binary_up_counter_out;
    wire        flag  = count_enable_flag_out;
    wire        load  = load_enable_in;
    wire        clr   = clear_by_chan_a_enable_in;
    wire        a_hit = flag && count_source_select_in == 3'h0 && !chan_a_mode_field_in[1]
                        && cnt == chan_a_compare_capture_out;

    a_load_clears: assert property (load |=> cnt == 16'h0000)
        else $error("load did not clear counter");
    a_flag_write: assert property (count_enable_wr_in |=> flag == $past(count_enable_wdata_in))
        else $error("count enable write lost");
    a_count_up: assert property (flag && count_source_select_in == 3'h0 && !load && !clr
        && !fast_pwm_enable_in |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter missed a tick");
    a_stopped_hold: assert property (!flag && !load && !clr |=> $stable(cnt))
        else $error("counter moved while stopped");
    a_presc_gate: assert property (count_source_select_in inside {3'h1, 3'h2}
        && !prescaler_enable_in && !load && !clr |=> $stable(cnt))
        else $error("divided tick without prescaler");
    a_match_clear: assert property (a_hit && clr && !load |=> cnt == 16'h0000)
        else $error("match did not clear counter");
    a_one_shot_stop: assert property (a_hit && one_shot_enable_in && !count_enable_wr_in
        && !trigger_enable_in |=> !flag)
        else $error("one shot did not stop");
    a_single_write: assert property (chan_a_write_in && chan_a_mode_field_in == 2'h0
        |=> chan_a_compare_capture_out == $past(write_data_in))
        else $error("single buffer write not applied");
    a_double_hold: assert property (chan_b_write_in && chan_b_mode_field_in == 2'h1 && !load
        && !flag && !chan_a_mode_field_in[1] |=> $stable(chan_b_compare_capture_out))
        else $error("double buffer write applied early");
    a_load_out_level: assert property (load ##1 (load && chan_a_output_mode_in == 3'h1)
        |=> chan_a_pin_out == $past(chan_a_polarity_in))
        else $error("output reset level wrong");

    c_one_shot: cover property ($fell(flag) && one_shot_enable_in);
    c_capture: cover property (chan_a_mode_field_in[1] && $changed(chan_a_compare_capture_out));
    c_match: cover property (a_hit && clr);
endmodule // timer_checker

bind updown_capture_compare_pwm_timer timer_checker u_timer_checker (
    .clk_in, .rst_n_in, .count_source_select_in, .prescaler_enable_in, .load_enable_in,
    .count_enable_wr_in, .count_enable_wdata_in, .trigger_enable_in,
    .clear_by_chan_a_enable_in, .one_shot_enable_in, .chan_a_mode_field_in,
    .chan_b_mode_field_in, .chan_a_polarity_in, .chan_a_output_mode_in, .fast_pwm_enable_in,
    .chan_a_write_in, .chan_b_write_in, .write_data_in, .chan_a_pin_out,
    .binary_up_counter_out, .chan_a_compare_capture_out, .chan_b_compare_capture_out,
    .count_enable_flag_out);
`default_nettype wire

// ---- testbench/timer_pin_model.sv ----
// Pin driver standing in for the parts wired to the timer's pins
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
    input  wire  clk_in,
    output logic trigger_pin_out,
    output logic chan_a_pin_out,
    output logic chan_b_pin_out
);
    initial begin
        trigger_pin_out = 1'h1;
        chan_a_pin_out  = 1'h0;
        chan_b_pin_out  = 1'h0;
    end
    // Levels held two clocks at least; shorter ones may slip the sampler
    task automatic hold_pin(input int which, input logic v, input int n);
        @(negedge clk_in);
        case (which)
            0: trigger_pin_out = v;        // Start edge set by channel A polarity
            1: chan_a_pin_out  = v;        // Capture edge
            default: chan_b_pin_out = v;   // Count edge set by channel B polarity
        endcase
        repeat ((n < 2) ? 2 : n) @(negedge clk_in);
    endtask
endmodule // timer_pin_model
`default_nettype wire

// ---- testbench/updown_capture_compare_pwm_timer_test.sv ----
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module updown_capture_compare_pwm_timer_test;
    typedef struct packed {
        logic [2:0]  src;
        logic        presc;
        logic [7:0]  ticks;
        logic [15:0] count;
    } row_t;
    // Source, prescaler on, cycles run, counter expected
    row_t rows [7] = '{
        '{3'h0, 1'h0, 8'h05, 16'h0005}, '{3'h0, 1'h0, 8'h01, 16'h0001},
        '{3'h1, 1'h0, 8'h40, 16'h0000}, '{3'h1, 1'h1, 8'h40, 16'h0008},
        '{3'h2, 1'h1, 8'h40, 16'h0002}, '{3'h2, 1'h0, 8'h40, 16'h0000},
        '{3'h6, 1'h1, 8'h40, 16'h0000}};
    logic        clk_in = 1'h0, rst_n_in = 1'h0;
    logic [2:0]  src = 3'h0, a_out_mode = 3'h0;
    logic        presc = 1'h0, load = 1'h0, ce_wr = 1'h0, ce_d = 1'h0, trig_en = 1'h0;
    logic        clr_en = 1'h0, one_shot = 1'h0, a_pol = 1'h0, b_pol = 1'h0;
    logic        a_cap_en = 1'h0, a_wr = 1'h0, b_wr = 1'h0, pwm_en = 1'h0;
    logic [1:0]  a_mode = 2'h0, b_mode = 2'h0;
    logic [15:0] wdata = 16'h0000, v;
    wire         trig_pin, a_drv, b_drv, a_po, a_oe_n, b_po, b_oe_n, flag;
    wire  [15:0] cnt, ca, cb;
    // Two-way pins: the timer wins while its driver is on
    wire         a_wire = a_oe_n ? a_drv : a_po;
    wire         b_wire = b_oe_n ? b_drv : b_po;
    integer      err_count = 0, n_checks = 0, i, k;

    updown_capture_compare_pwm_timer u_updown_capture_compare_pwm_timer (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .count_source_select_in(src),
        .prescaler_enable_in(presc), .load_enable_in(load),
        .count_enable_wr_in(ce_wr), .count_enable_wdata_in(ce_d),
        .trigger_enable_in(trig_en), .clear_by_chan_a_enable_in(clr_en),
        .one_shot_enable_in(one_shot), .chan_a_mode_field_in(a_mode),
        .chan_b_mode_field_in(b_mode), .chan_a_polarity_in(a_pol),
        .chan_b_polarity_in(b_pol), .chan_a_capture_enable_in(a_cap_en),
        .chan_a_output_mode_in(a_out_mode), .chan_b_output_mode_in(3'h0),
        .fast_pwm_enable_in(pwm_en), .pwm_resolution_in(2'h0),
        .chan_a_write_in(a_wr), .chan_b_write_in(b_wr), .write_data_in(wdata),
        .trigger_pin_in(trig_pin), .chan_a_pin_in(a_wire), .chan_b_pin_in(b_wire),
        .chan_a_pin_out(a_po), .chan_a_pin_oe_n_out(a_oe_n),
        .chan_b_pin_out(b_po), .chan_b_pin_oe_n_out(b_oe_n),
        .binary_up_counter_out(cnt), .chan_a_compare_capture_out(ca),
        .chan_b_compare_capture_out(cb), .count_enable_flag_out(flag));
    timer_pin_model u_timer_pin_model (
        .clk_in(clk_in), .trigger_pin_out(trig_pin), .chan_a_pin_out(a_drv),
        .chan_b_pin_out(b_drv));

    always #2 clk_in = ~clk_in;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic load_pulse;
        @(negedge clk_in);
        load = 1'h1;
        repeat (2) @(negedge clk_in);
        load = 1'h0;
    endtask
    task automatic set_flag(input logic d);
        @(negedge clk_in);
        ce_wr = 1'h1;
        ce_d  = d;
        @(negedge clk_in);
        ce_wr = 1'h0;
    endtask
    // Exactly n counting edges after the edge that raises the flag
    task automatic run(input int n);
        @(negedge clk_in);
        ce_wr = 1'h1;
        ce_d  = 1'h1;
        repeat (n) @(negedge clk_in);
        ce_d  = 1'h0;
        @(negedge clk_in);
        ce_wr = 1'h0;
    endtask
    task automatic wr_chan(input logic b, input logic [15:0] d);
        @(negedge clk_in);
        wdata = d;
        a_wr  = !b;
        b_wr  = b;
        @(negedge clk_in);
        a_wr  = 1'h0;
        b_wr  = 1'h0;
    endtask
    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_flag(input logic lvl);
        for (k = 0; k < 40 && flag !== lvl; k++) @(negedge clk_in);
        check(flag, lvl, "count enable flag");
        if (flag !== lvl) finish_test;
    endtask

    initial begin
        repeat (6) @(negedge clk_in);
        check(cnt, 16'h0000, "counter in reset");
        check(a_oe_n, 1'h1, "pin A driver in reset");
        rst_n_in = 1'h1;
        for (i = 0; i < 7; i++) begin
            src   = rows[i].src;
            presc = rows[i].presc;
            load_pulse;
            run(rows[i].ticks);
            check(cnt, rows[i].count, "ticks counted");
            $display("row %0d done", i);
        end
        src = 3'h0;
        clr_en = 1'h1;
        a_mode = 2'h1;
        b_mode = 2'h1;
        a_out_mode = 3'h1;
        wr_chan(1'h0, 16'h0009);
        check(ca, 16'h0000, "A held in buffer");
        load_pulse;
        check(ca, 16'h0009, "A moved on load");
        wr_chan(1'h1, 16'h0004);
        check(cb, 16'h0000, "B held in buffer");
        run(10);
        check(cnt, 16'h0000, "cleared on A match");
        check(cb, 16'h0004, "B moved on A match");
        @(negedge clk_in);
        check(a_po, 1'h1, "A set on match");
        $display("double buffer done");
        one_shot = 1'h1;
        a_mode = 2'h0;
        wr_chan(1'h0, 16'h0005);
        check(ca, 16'h0005, "A single write");
        load_pulse;
        set_flag(1'h1);
        wait_flag(1'h0);
        check(cnt, 16'h0000, "one shot end");
        $display("one shot done");
        trig_en = 1'h1;
        for (i = 0; i < 2; i++) begin
            a_pol = i[0];
            load_pulse;
            repeat (2) begin
                u_timer_pin_model.hold_pin(0, !i[0], 3);
                u_timer_pin_model.hold_pin(0, i[0], 3);
                wait_flag(1'h1);
                wait_flag(1'h0);
            end
            $display("trigger run %0d done", i);
        end
        trig_en = 1'h0;
        a_pol = 1'h0;
        one_shot = 1'h0;
        clr_en = 1'h0;
        a_mode = 2'h2;
        a_out_mode = 3'h0;
        load_pulse;
        set_flag(1'h1);
        u_timer_pin_model.hold_pin(1, 1'h1, 5);
        check(ca, 16'h0005, "capture gated");
        u_timer_pin_model.hold_pin(1, 1'h0, 5);
        a_cap_en = 1'h1;
        for (i = 2; i < 4; i++) begin
            a_mode = i[1:0];
            v = ca;
            u_timer_pin_model.hold_pin(1, 1'h1, 6);
            check(ca !== v, 1'h1, "capture on rise");
            v = ca;
            u_timer_pin_model.hold_pin(1, 1'h0, 6);
            check(ca !== v, i == 3, "capture on fall");
        end
        $display("capture done");
        set_flag(1'h0);
        src = 3'h3;
        b_pol = 1'h1;
        load_pulse;
        set_flag(1'h1);
        repeat (3) begin
            u_timer_pin_model.hold_pin(2, 1'h1, 3);
            u_timer_pin_model.hold_pin(2, 1'h0, 3);
        end
        repeat (3) @(negedge clk_in);
        check(cnt, 16'h0003, "pin B falling edges");
        $display("pin source done");
        set_flag(1'h0);
        src = 3'h0;
        a_mode = 2'h1;
        a_out_mode = 3'h1;
        pwm_en = 1'h1;
        wr_chan(1'h0, 16'h8000);
        load_pulse;
        run(16'h0090);
        @(negedge clk_in);
        check(a_po, 1'h1, "pwm set past duty");
        set_flag(1'h1);
        wr_chan(1'h0, 16'h4000);
        check(ca, 16'h8000, "pwm write held");
        run(16'h03bc);
        @(negedge clk_in);
        check(cnt, 16'h0050, "pwm period wrap");
        check(ca, 16'h4000, "pwm update on wrap");
        check(a_po, 1'h1, "pwm new duty");
        $display("pwm done");
        finish_test;
    end
endmodule // updown_capture_compare_pwm_timer_test
`default_nettype wire
